// >>> tgc_consts.svh
// Constants for the timer gate control block
`ifndef TGC_CONSTS_SVH
`define TGC_CONSTS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define TGC_ADDR_MAIN 4'h0
`define TGC_ADDR_GATE 4'h4
`define TGC_ADDR_CNTL 4'h8
`define TGC_ADDR_CNTH 4'hC
`define TGC_ADDR_STAT 5'h10
`define TGC_ADDR_MASK 5'h14
// ----------------------------------------
// Gate control fields and main timer-on bit
// ----------------------------------------
`define TGC_BIT_GE 7
`define TGC_BIT_POL 6
`define TGC_BIT_TM 5
`define TGC_BIT_SPM 4
`define TGC_BIT_GO 3
`define TGC_BIT_VAL 2
`define TGC_MAIN_ON 0
// ----------------------------------------
// Source codes, reset values and interrupt width
// ----------------------------------------
`define TGC_SRC_PIN 2'b00
`define TGC_SRC_OVF 2'b01
`define TGC_SRC_MATCH 2'b10
`define TGC_RST_BYTE 8'h00
`define TGC_RST_CNT 16'h0000
`define TGC_INT_W 2
`endif

// >>> tgc_gate_model.sv
// Gate source model: drives the selected source, the other sources inverted
module tgc_gate_model (
    input wire logic [1:0] sel,
    input wire logic lvl,
    output logic gate_pin,
    output logic companion_overflow,
    output logic period_match
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Unselected sources show the opposite level
    // ----------------------------------------
    assign gate_pin = (sel == 2'h0) ? lvl : !lvl;
    assign companion_overflow = (sel == 2'h1) ? lvl : !lvl;
    assign period_match = (sel == 2'h2) ? lvl : !lvl;
endmodule

// >>> tgc_pkg.sv
// Types for the timer gate control block
package tgc_pkg;
    typedef enum logic [1:0] {
        TGC_SP_IDLE = 2'b00,
        TGC_SP_ARMED = 2'b01,
        TGC_SP_OPEN = 2'b10
    } tgc_sp_e;
    typedef logic [1:0] tgc_src_t;
endpackage

// >>> tgc_sync.sv
// Three-stage synchroniser with agreement of the last two stages
module tgc_sync
    import tgc_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    if (WIDTH < 1) begin : g_bad_width
        $error("tgc_sync width must be positive");
    end
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1[i] <= 1'b0;
                    s2[i] <= 1'b0;
                    s3[i] <= 1'b0;
                    dout[i] <= 1'b0;
                end else begin
                    s1[i] <= din[i];
                    s2[i] <= s1[i];
                    s3[i] <= s2[i];
                    if (s2[i] == s3[i]) begin
                        dout[i] <= s3[i];
                    end
                end
            end
        end
    endgenerate
endmodule

// >>> tgc_top.sv
// Timer gate control with 16-bit counter and AHB-Lite registers
// Operation
// - Gate polarity 1 counts while the gate is high, 0 while it is low.
// - Toggle mode routes the gate through a toggle flip-flop.
// - Writing toggle mode 0 disables toggling and clears the toggle flip-flop.
// - In toggle mode the flip-flop changes on each rising edge of the selected gate.
// - Software arms an acquisition by setting go/done in a write that also sets single-pulse mode; it reads 1 while waiting.
// - Hardware clears go/done when the acquisition completes.
// - Gate value shows the processed gate, qualified by single-pulse control when that mode is on, whatever gate enable says.
// - Source select picks pin, companion overflow or period match; 11 is reserved.
// - Writable gate bits reset to 0 on power-on reset.
// - The count is 16 bits, reached as high and low byte registers.
`include "tgc_consts.svh"
module tgc_top
    import tgc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic gate_pin,
    input wire logic companion_overflow,
    input wire logic period_match,
    output logic [15:0] count,
    output logic irq
);
    // ----------------------------------------
    // Registers and bus capture
    // ----------------------------------------
    logic [7:0] main_ctl;
    logic [7:0] gate_ctl;
    logic [15:0] cnt;
    logic [`TGC_INT_W-1:0] int_stat;
    logic [`TGC_INT_W-1:0] int_mask;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic pin_s;
    logic [2:0] src_raw;
    logic [2:0] src_s;
    logic sel_gate;
    logic sel_prev;
    logic sel_rise;
    logic tog_ff;
    logic pol_gate;
    logic proc_gate;
    tgc_sp_e sp_state;
    logic sp_qual;
    logic gate_val;
    logic count_en;
    logic sp_done;
    logic cnt_wrap;
    logic wr_go;
    logic wr_gate;
    logic [7:0] wd;
    assign wd = hwdata[7:0];
    assign wr_go = wr_pend && (wr_addr == {4'h0, `TGC_ADDR_GATE}) && wd[`TGC_BIT_GO];
    assign wr_gate = wr_pend && (wr_addr == {4'h0, `TGC_ADDR_GATE});
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign count = cnt;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else if (hready) begin
            wr_pend <= hsel && htrans[1] && hwrite;
            wr_addr <= haddr[7:0];
        end else begin
            wr_pend <= 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (hready && hsel && htrans[1] && !hwrite) begin
            case (haddr[7:0])
                {4'h0, `TGC_ADDR_MAIN}: hrdata <= {24'h00_0000, main_ctl};
                {4'h0, `TGC_ADDR_GATE}: hrdata <= {24'h00_0000, gate_ctl[7:3], gate_val,
                    gate_ctl[1:0]};
                {4'h0, `TGC_ADDR_CNTL}: hrdata <= {24'h00_0000, cnt[7:0]};
                {4'h0, `TGC_ADDR_CNTH}: hrdata <= {24'h00_0000, cnt[15:8]};
                {3'h0, `TGC_ADDR_STAT}: hrdata <= {30'h0000_0000, int_stat};
                {3'h0, `TGC_ADDR_MASK}: hrdata <= {30'h0000_0000, int_mask};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
    // ----------------------------------------
    // Control registers
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            main_ctl <= `TGC_RST_BYTE;
        end else if (wr_pend && wr_addr == {4'h0, `TGC_ADDR_MAIN}) begin
            main_ctl <= {wd[7:2], 1'b0, wd[0]};
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            gate_ctl <= `TGC_RST_BYTE;
        end else begin
            if (wr_gate) begin
                gate_ctl[7:4] <= wd[7:4];
                gate_ctl[1:0] <= wd[1:0];
            end
            gate_ctl[2] <= 1'b0;
            if (wr_go && wd[`TGC_BIT_SPM]) begin
                gate_ctl[`TGC_BIT_GO] <= 1'b1;
            end else if (sp_done || (wr_gate && !wd[`TGC_BIT_SPM])) begin
                gate_ctl[`TGC_BIT_GO] <= 1'b0;
            end
        end
    end
    // ----------------------------------------
    // Gate path
    // ----------------------------------------
    tgc_sync #(.WIDTH(3)) tgc_sync_i (
        .hclk(hclk),
        .hresetn(hresetn),
        .din({period_match, companion_overflow, gate_pin}),
        .dout(src_raw)
    );
    assign src_s = src_raw;
    assign pin_s = src_s[0];
    always_comb begin
        case (gate_ctl[1:0])
            `TGC_SRC_PIN: sel_gate = pin_s;
            `TGC_SRC_OVF: sel_gate = src_s[1];
            `TGC_SRC_MATCH: sel_gate = src_s[2];
            default: sel_gate = 1'b0;
        endcase
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sel_prev <= 1'b0;
        end else begin
            sel_prev <= sel_gate;
        end
    end
    assign sel_rise = sel_gate && !sel_prev;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tog_ff <= 1'b0;
        end else if (!gate_ctl[`TGC_BIT_TM]) begin
            tog_ff <= 1'b0;
        end else if (sel_rise) begin
            tog_ff <= !tog_ff;
        end
    end
    assign pol_gate = gate_ctl[`TGC_BIT_TM] ? tog_ff : sel_gate;
    assign proc_gate = gate_ctl[`TGC_BIT_POL] ? pol_gate : !pol_gate;
    // ----------------------------------------
    // Single-pulse control
    // ----------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sp_state <= TGC_SP_IDLE;
        end else if (wr_gate && !wd[`TGC_BIT_SPM]) begin
            sp_state <= TGC_SP_IDLE;
        end else if (wr_go && wd[`TGC_BIT_SPM]) begin
            sp_state <= TGC_SP_ARMED;
        end else if (!gate_ctl[`TGC_BIT_SPM]) begin
            sp_state <= TGC_SP_IDLE;
        end else begin
            case (sp_state)
                TGC_SP_IDLE: sp_state <= TGC_SP_IDLE;
                TGC_SP_ARMED: if (proc_gate) sp_state <= TGC_SP_OPEN;
                TGC_SP_OPEN: if (!proc_gate) sp_state <= TGC_SP_IDLE;
                default: sp_state <= TGC_SP_IDLE;
            endcase
        end
    end
    assign sp_done = gate_ctl[`TGC_BIT_SPM] && sp_state == TGC_SP_OPEN && !proc_gate;
    assign sp_qual = !gate_ctl[`TGC_BIT_SPM] || (sp_state != TGC_SP_IDLE && proc_gate) &&
        (sp_state == TGC_SP_OPEN || sp_state == TGC_SP_ARMED);
    assign gate_val = proc_gate && sp_qual;
    assign count_en = main_ctl[`TGC_MAIN_ON] &&
        (!gate_ctl[`TGC_BIT_GE] || gate_val);
    // ----------------------------------------
    // Counter
    // ----------------------------------------
    assign cnt_wrap = count_en && cnt == 16'hFFFF;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt <= `TGC_RST_CNT;
        end else if (wr_pend && wr_addr == {4'h0, `TGC_ADDR_CNTL}) begin
            cnt[7:0] <= wd;
        end else if (wr_pend && wr_addr == {4'h0, `TGC_ADDR_CNTH}) begin
            cnt[15:8] <= wd;
        end else if (count_en) begin
            cnt <= cnt + 16'h0001;
        end
    end
    // ----------------------------------------
    // Interrupts
    // ----------------------------------------
    logic [`TGC_INT_W-1:0] int_set;
    logic stat_wr;
    assign int_set = {sp_done, cnt_wrap};
    assign stat_wr = wr_pend && wr_addr == {3'h0, `TGC_ADDR_STAT};
    if (`TGC_INT_W != 2) begin : g_int_check
        $error("tgc_top serves exactly two status events");
    end
    // Set wins over a clear in the same cycle
    genvar k;
    generate
        for (k = 0; k < `TGC_INT_W; k++) begin : g_stat
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    int_stat[k] <= 1'b0;
                end else if (int_set[k]) begin
                    int_stat[k] <= 1'b1;
                end else if (stat_wr && hwdata[k]) begin
                    int_stat[k] <= 1'b0;
                end
            end
        end
    endgenerate
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            int_mask <= '0;
        end else if (wr_pend && wr_addr == {3'h0, `TGC_ADDR_MASK}) begin
            int_mask <= hwdata[`TGC_INT_W-1:0];
        end
    end
    assign irq = |(int_stat & int_mask);
    // ----------------------------------------
    // Checks
    // ----------------------------------------
    a_off_no_count: assert property (@(posedge hclk) disable iff (!hresetn)
        !main_ctl[`TGC_MAIN_ON] && !wr_pend |=> $stable(cnt))
        else $error("count moved while off");
    a_free_count: assert property (@(posedge hclk) disable iff (!hresetn)
        main_ctl[`TGC_MAIN_ON] && !gate_ctl[`TGC_BIT_GE] && !wr_pend |=>
        cnt == $past(cnt) + 16'h0001)
        else $error("free count missed");
    a_gate_count: assert property (@(posedge hclk) disable iff (!hresetn)
        main_ctl[`TGC_MAIN_ON] && gate_ctl[`TGC_BIT_GE] && !wr_pend |=>
        cnt == $past(cnt) + {15'h0000, $past(gate_val)})
        else $error("gated count wrong");
    a_main_write: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend && wr_addr == {4'h0, `TGC_ADDR_MAIN} |=>
        main_ctl[`TGC_MAIN_ON] == $past(wd[`TGC_MAIN_ON]))
        else $error("timer on not written");
    a_pol_level: assert property (@(posedge hclk) disable iff (!hresetn)
        !gate_ctl[`TGC_BIT_TM] && !gate_ctl[`TGC_BIT_SPM] |->
        gate_val == (gate_ctl[`TGC_BIT_POL] ~^ sel_gate))
        else $error("polarity wrong");
    a_tog_route: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[`TGC_BIT_TM] && !gate_ctl[`TGC_BIT_SPM] |->
        gate_val == (gate_ctl[`TGC_BIT_POL] ~^ tog_ff))
        else $error("toggle not routed");
    a_tog_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        !gate_ctl[`TGC_BIT_TM] |=> !tog_ff)
        else $error("toggle not cleared");
    a_tog_edge: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[`TGC_BIT_TM] && sel_rise && !wr_gate |=> tog_ff != $past(tog_ff))
        else $error("toggle missed edge");
    a_tog_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[`TGC_BIT_TM] && !sel_rise && !wr_gate |=> $stable(tog_ff))
        else $error("toggle moved without edge");
    a_sp_block: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[`TGC_BIT_SPM] && sp_state == TGC_SP_IDLE |-> !gate_val)
        else $error("gate passed while not armed");
    a_sp_open: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[`TGC_BIT_SPM] && sp_state == TGC_SP_ARMED && proc_gate && !wr_gate |=>
        sp_state == TGC_SP_OPEN)
        else $error("pulse window not opened");
    a_sp_off_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        !gate_ctl[`TGC_BIT_SPM] && !wr_gate |=> sp_state == TGC_SP_IDLE)
        else $error("pulse control active while off");
    a_go_drop: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_gate && !wd[`TGC_BIT_SPM] |=> !gate_ctl[`TGC_BIT_GO])
        else $error("go kept with pulse mode off");
    a_go_set: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_go && wd[`TGC_BIT_SPM] |=> gate_ctl[`TGC_BIT_GO])
        else $error("go not set");
    a_sp_arm: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_go && wd[`TGC_BIT_SPM] |=> sp_state == TGC_SP_ARMED)
        else $error("acquisition not armed");
    a_arm_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[`TGC_BIT_GO] |-> sp_state != TGC_SP_IDLE)
        else $error("go set while not waiting");
    a_arm_keep: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[`TGC_BIT_GO] && !sp_done && !wr_gate |=> gate_ctl[`TGC_BIT_GO])
        else $error("go dropped early");
    a_done_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        sp_done && !wr_go |=> !gate_ctl[`TGC_BIT_GO])
        else $error("done not cleared");
    a_sp_done_idle: assert property (@(posedge hclk) disable iff (!hresetn)
        sp_done && !wr_go |=> sp_state == TGC_SP_IDLE)
        else $error("pulse control not idle after done");
    a_done_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        sp_done |=> int_stat[1])
        else $error("done status not set");
    a_stat_clear: assert property (@(posedge hclk) disable iff (!hresetn)
        stat_wr && hwdata[1] && !sp_done |=> !int_stat[1])
        else $error("done status not cleared");
    a_src_reserved: assert property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[1:0] == 2'b11 |-> !sel_gate)
        else $error("reserved source");
    a_cnt_low: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend && wr_addr == {4'h0, `TGC_ADDR_CNTL} |=> cnt[7:0] == $past(wd))
        else $error("low byte not written");
    a_cnt_high: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_pend && wr_addr == {4'h0, `TGC_ADDR_CNTH} |=> cnt[15:8] == $past(wd))
        else $error("high byte not written");
    a_wrap_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        cnt_wrap && !wr_pend |=> cnt == 16'h0000)
        else $error("count did not wrap");
    a_wrap_flag: assert property (@(posedge hclk) disable iff (!hresetn)
        cnt_wrap |=> int_stat[0])
        else $error("wrap status not set");
    c_single_pulse: cover property (@(posedge hclk) disable iff (!hresetn) sp_done);
    c_toggle: cover property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[`TGC_BIT_TM] && sel_rise);
    c_irq: cover property (@(posedge hclk) disable iff (!hresetn) irq);
    c_arm_wait: cover property (@(posedge hclk) disable iff (!hresetn)
        sp_state == TGC_SP_ARMED && proc_gate);
    c_match_src: cover property (@(posedge hclk) disable iff (!hresetn)
        gate_ctl[1:0] == `TGC_SRC_MATCH && gate_val);
endmodule

// >>> timer_gate_control_test.sv
// Self-checking bench for the timer gate control block
`include "tgc_consts.svh"
module timer_gate_control_test;
    timeunit 1ns;
    timeprecision 1ns;
    typedef struct packed {
        logic [7:0] ctl;
        logic lvl;
        logic val;
        logic run;
    } tgc_row_s;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq, lvl;
    logic gate_pin, companion_overflow, period_match;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, sel;
    logic [2:0] hsize;
    logic [15:0] count, c0;
    int fails, checked;
    tgc_row_s rows [9] = '{'{8'hC0, 1'b1, 1'b1, 1'b1}, '{8'hC0, 1'b0, 1'b0, 1'b0},
        '{8'h80, 1'b0, 1'b1, 1'b1}, '{8'h80, 1'b1, 1'b0, 1'b0}, '{8'hC1, 1'b1, 1'b1, 1'b1},
        '{8'hC2, 1'b1, 1'b1, 1'b1}, '{8'hC3, 1'b1, 1'b0, 1'b0}, '{8'h83, 1'b1, 1'b1, 1'b1},
        '{8'h40, 1'b0, 1'b0, 1'b1}};
    assign hready = hreadyout;
    tgc_top tgc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gate_pin(gate_pin),
        .companion_overflow(companion_overflow), .period_match(period_match),
        .count(count), .irq(irq));
    tgc_gate_model tgc_gate_model_i (.sel(sel), .lvl(lvl), .gate_pin(gate_pin),
        .companion_overflow(companion_overflow), .period_match(period_match));
    // ----------------------------------------
    // Bus cycles and comparisons
    // ----------------------------------------
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge hclk);
    endtask
    task automatic runs(input logic exp);
        c0 = count;
        idle(4);
        chk1(count !== c0, exp);
    endtask
    task automatic val_is(input int b, input logic exp);
        bus(1'b0, 32'(`TGC_ADDR_GATE), 32'h0000_0000);
        chk1(rd[b], exp);
    endtask
    task automatic pulse;
        lvl <= 1'b1;
        idle(8);
        lvl <= 1'b0;
        idle(8);
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Clock, watchdog and test sequence
    // ----------------------------------------
    initial begin
        hclk = 1'b0;
        forever #10 hclk = ~hclk;
    end
    initial begin
        idle(5000);
        fails++;
        results();
    end
    initial begin
        {hresetn, hsel, hwrite, lvl, sel, htrans} = '0;
        {haddr, hwdata} = '0;
        hsize = 3'h2;
        fails = 0;
        checked = 0;
        idle(3);
        hresetn <= 1'b1;
        bus(1'b0, 32'(`TGC_ADDR_GATE), 32'h0000_0000);
        chk32(rd, 32'h0000_0004);
        bus(1'b1, 32'h0000_0020, 32'h0000_00FF);
        bus(1'b0, 32'h0000_0020, 32'h0000_0000);
        chk32(rd, 32'h0000_0000);
        bus(1'b1, 32'(`TGC_ADDR_CNTL), 32'h0000_0034);
        bus(1'b1, 32'(`TGC_ADDR_CNTH), 32'h0000_0012);
        idle(1);
        chk32({16'h0000, count}, 32'h0000_1234);
        bus(1'b0, 32'(`TGC_ADDR_CNTH), 32'h0000_0000);
        chk32(rd, 32'h0000_0012);
        lvl <= 1'b1;
        bus(1'b1, 32'(`TGC_ADDR_GATE), 32'h0000_00C0);
        runs(1'b0);
        bus(1'b1, 32'(`TGC_ADDR_MAIN), 32'h0000_0001);
        foreach (rows[i]) begin
            sel <= rows[i].ctl[1:0];
            lvl <= rows[i].lvl;
            bus(1'b1, 32'(`TGC_ADDR_GATE), {24'h00_0000, rows[i].ctl});
            idle(8);
            val_is(`TGC_BIT_VAL, rows[i].val);
            runs(rows[i].run);
        end
        sel <= 2'h0;
        lvl <= 1'b0;
        bus(1'b1, 32'(`TGC_ADDR_GATE), 32'h0000_00E0);
        pulse();
        val_is(`TGC_BIT_VAL, 1'b1);
        runs(1'b1);
        pulse();
        val_is(`TGC_BIT_VAL, 1'b0);
        pulse();
        bus(1'b1, 32'(`TGC_ADDR_GATE), 32'h0000_00C0);
        bus(1'b1, 32'(`TGC_ADDR_GATE), 32'h0000_00E0);
        idle(8);
        val_is(`TGC_BIT_VAL, 1'b0);
        bus(1'b1, 32'(`TGC_ADDR_GATE), 32'h0000_00D8);
        val_is(`TGC_BIT_GO, 1'b1);
        runs(1'b0);
        lvl <= 1'b1;
        idle(8);
        runs(1'b1);
        lvl <= 1'b0;
        idle(8);
        val_is(`TGC_BIT_GO, 1'b0);
        lvl <= 1'b1;
        idle(8);
        runs(1'b0);
        chk1(irq, 1'b0);
        bus(1'b0, 32'(`TGC_ADDR_STAT), 32'h0000_0000);
        chk32(rd, 32'h0000_0002);
        bus(1'b1, 32'(`TGC_ADDR_MASK), 32'h0000_0002);
        idle(2);
        chk1(irq, 1'b1);
        bus(1'b1, 32'(`TGC_ADDR_STAT), 32'h0000_0002);
        idle(2);
        chk1(irq, 1'b0);
        chk1(hresp, 1'b0);
        bus(1'b1, 32'(`TGC_ADDR_MAIN), 32'h0000_0000);
        bus(1'b1, 32'(`TGC_ADDR_CNTL), 32'h0000_00FF);
        bus(1'b1, 32'(`TGC_ADDR_CNTH), 32'h0000_00FF);
        bus(1'b1, 32'(`TGC_ADDR_GATE), 32'h0000_0000);
        bus(1'b1, 32'(`TGC_ADDR_MAIN), 32'h0000_0001);
        idle(4);
        bus(1'b0, 32'(`TGC_ADDR_STAT), 32'h0000_0000);
        chk32(rd, 32'h0000_0001);
        lvl <= 1'b0;
        hresetn <= 1'b0;
        idle(2);
        hresetn <= 1'b1;
        chk32({16'h0000, count}, 32'h0000_0000);
        chk1(irq, 1'b0);
        bus(1'b0, 32'(`TGC_ADDR_GATE), 32'h0000_0000);
        chk32(rd, 32'h0000_0004);
        bus(1'b0, 32'(`TGC_ADDR_MAIN), 32'h0000_0000);
        chk32(rd, 32'h0000_0000);
        results();
    end
endmodule
